// ### inc/fwsr_pkg.sv
// Constants shared by the flash status polling controller.
// Assumes a 200 MHz clock and an asynchronous word-wide flash on pins.
package fwsr_pkg;

    // ************************************************
    // Widths
    // ************************************************
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;

    // ************************************************
    // Status bit positions
    // ************************************************
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE1 = 6;
    localparam int BIT_TIMEOUT = 5;
    localparam int BIT_ERASE_TIMER = 3;
    localparam int BIT_TOGGLE2 = 2;

    // ************************************************
    // Commands and answers
    // ************************************************
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_POLL = 2'h2;
    localparam logic [1:0] CMD_TIMER = 2'h3;
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_FAIL = 2'h1;
    localparam logic [1:0] ST_SUSPENDED = 2'h2;
    localparam logic [1:0] ST_ERASE_STARTED = 2'h3;
    localparam logic [15:0] RESET_CMD_DATA = 16'h00F0;
    localparam logic [21:0] RESET_CMD_ADDR = 22'h000000;

    // ************************************************
    // Bus cycle timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_SETUP_NS = 10;
    localparam int T_READ_NS = 90;
    localparam int T_WRITE_NS = 35;
    localparam int T_HOLD_NS = 20;
    localparam int SYNC_STAGES = 2;
    localparam logic [4:0] SETUP_CYC =
        5'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] READ_CYC =
        5'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
    localparam logic [4:0] WRITE_CYC =
        5'((T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] HOLD_CYC =
        5'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : fwsr_pkg

// ### logic/fwsr_bus.sv
// One asynchronous read or write cycle on the flash pins.
// Assumes the caller waits for done before starting the next cycle.
`timescale 1ns/1ps
`default_nettype none
module fwsr_bus (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Cycle request
    input wire logic start,
    input wire logic wr,
    input wire logic [21:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    // Flash pins
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [21:0] a,
    output logic [15:0] dq_o,
    output logic dq_oe_n,
    input wire logic [15:0] dq_i
);

    // ************************************************
    // State
    // ************************************************
    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_SETUP = 2'b01,
        B_STROBE = 2'b10,
        B_HOLD = 2'b11
    } fwsr_bst_t;

    typedef struct packed {
        fwsr_bst_t st;
        logic [4:0] cnt;
        logic wr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [21:0] a;
        logic [15:0] dq_o;
        logic dq_oe_n;
        logic [15:0] s1;
        logic [15:0] s2;
        logic done;
        logic [15:0] rdata;
    } fwsr_bus_s_t;

    localparam fwsr_bus_s_t RST = '{st: B_IDLE, cnt: 5'h00, wr: 1'b0,
        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, a: 22'h000000, dq_o: 16'h0000,
        dq_oe_n: 1'b1, s1: 16'h0000, s2: 16'h0000, done: 1'b0,
        rdata: 16'h0000};

    fwsr_bus_s_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.s1 = dq_i;
        d.s2 = q.s1;
        case (q.st)
            B_IDLE: begin
                if (start) begin
                    d.st = B_SETUP;
                    d.cnt = fwsr_pkg::SETUP_CYC - 5'h01;
                    d.wr = wr;
                    d.a = addr;
                    d.ce_n = 1'b0;
                    d.dq_o = wdata;
                    d.dq_oe_n = !wr;
                end
            end
            B_SETUP: begin
                if (q.cnt == 5'h00) begin
                    d.st = B_STROBE;
                    d.cnt = q.wr ? fwsr_pkg::WRITE_CYC - 5'h01
                                 : fwsr_pkg::READ_CYC - 5'h01;
                    d.oe_n = q.wr;
                    d.we_n = !q.wr;
                end else begin
                    d.cnt = q.cnt - 5'h01;
                end
            end
            B_STROBE: begin
                if (q.cnt == 5'h00) begin
                    if (!q.wr) begin
                        d.rdata = q.s2;
                    end
                    d.st = B_HOLD;
                    d.cnt = fwsr_pkg::HOLD_CYC - 5'h01;
                    d.oe_n = 1'b1;
                    d.we_n = 1'b1;
                    d.ce_n = 1'b1;
                end else begin
                    d.cnt = q.cnt - 5'h01;
                end
            end
            B_HOLD: begin
                if (q.cnt == 5'h00) begin
                    d.st = B_IDLE;
                    d.dq_oe_n = 1'b1;
                    d.done = 1'b1;
                end else begin
                    d.cnt = q.cnt - 5'h01;
                end
            end
            default: d = RST;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;
    assign rdata = q.rdata;
    assign ce_n = q.ce_n;
    assign oe_n = q.oe_n;
    assign we_n = q.we_n;
    assign a = q.a;
    assign dq_o = q.dq_o;
    assign dq_oe_n = q.dq_oe_n;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_one_strobe: assert property (!(!oe_n && !we_n))
        else $error("Read and write strobes low together");
    chk_ce_framing: assert property ((!oe_n || !we_n) |-> !ce_n)
        else $error("Strobe low without chip select");
    chk_write_drive: assert property ($rose(we_n) |-> !dq_oe_n)
        else $error("Write data released before write strobe rose");

endmodule : fwsr_bus
`default_nettype wire

// ### logic/fwsr_ctrl.sv
// Host controller that issues flash bus cycles and polls write status.
// Assumes one flash on the pins and the ready/busy wire pulled up outside.
`timescale 1ns/1ps
`default_nettype none
module fwsr_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // User command
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_kind,
    input wire logic [21:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_abort,
    output logic cmd_ready,
    // User answer
    output logic rsp_valid,
    output logic [1:0] rsp_status,
    output logic [15:0] rsp_data,
    output logic busy,
    // Flash pins
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [21:0] a,
    output logic [15:0] dq_o,
    output logic dq_oe_n,
    input wire logic [15:0] dq_i,
    input wire logic ready_busy_n
);

    // ************************************************
    // State
    // ************************************************
    typedef enum logic [2:0] {
        T_IDLE = 3'b000,
        T_USER = 3'b001,
        T_RD1 = 3'b010,
        T_RD2 = 3'b011,
        T_RD3 = 3'b100,
        T_RST = 3'b101
    } fwsr_tst_t;

    typedef struct packed {
        fwsr_tst_t st;
        logic [1:0] kind;
        logic [21:0] addr;
        logic [7:0] first;
        logic abort;
        logic [1:0] reads;
        logic start;
        logic wr;
        logic [21:0] baddr;
        logic [15:0] bdata;
        logic ready;
        logic rvalid;
        logic [1:0] rstatus;
        logic [15:0] rdata;
        logic rb1;
        logic rb2;
        logic busy;
    } fwsr_ctrl_s_t;

    localparam fwsr_ctrl_s_t RST = '{st: T_IDLE, kind: 2'h0,
        addr: 22'h000000, first: 8'h00, abort: 1'b0, reads: 2'h0,
        start: 1'b0, wr: 1'b0, baddr: 22'h000000, bdata: 16'h0000,
        ready: 1'b0, rvalid: 1'b0, rstatus: 2'h0, rdata: 16'h0000,
        rb1: 1'b1, rb2: 1'b1, busy: 1'b0};

    fwsr_ctrl_s_t q, d;
    logic bus_done;
    logic [15:0] bus_rdata;
    logic tog1;
    logic tog2;

    fwsr_bus u_bus (
        .clk(clk),
        .resetn(resetn),
        .start(q.start),
        .wr(q.wr),
        .addr(q.baddr),
        .wdata(q.bdata),
        .done(bus_done),
        .rdata(bus_rdata),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .a(a),
        .dq_o(dq_o),
        .dq_oe_n(dq_oe_n),
        .dq_i(dq_i)
    );

    assign tog1 = bus_rdata[fwsr_pkg::BIT_TOGGLE1] !=
                  q.first[fwsr_pkg::BIT_TOGGLE1];
    assign tog2 = bus_rdata[fwsr_pkg::BIT_TOGGLE2] !=
                  q.first[fwsr_pkg::BIT_TOGGLE2];

    // ************************************************
    // Sequencer
    // ************************************************
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.rvalid = 1'b0;
        d.rb1 = ready_busy_n;
        d.rb2 = q.rb1;
        d.busy = !q.rb2;
        if (cmd_abort && q.st != T_IDLE) begin
            d.abort = 1'b1;
        end
        case (q.st)
            T_IDLE: begin
                d.ready = 1'b1;
                d.abort = 1'b0;
                d.reads = 2'h0;
                if (cmd_valid && q.ready) begin
                    d.ready = 1'b0;
                    d.kind = cmd_kind;
                    d.addr = cmd_addr;
                    d.start = 1'b1;
                    d.wr = (cmd_kind == fwsr_pkg::CMD_WRITE);
                    d.baddr = cmd_addr;
                    d.bdata = cmd_wdata;
                    d.st = (cmd_kind == fwsr_pkg::CMD_POLL) ? T_RD1
                                                            : T_USER;
                end
            end
            T_USER: begin
                if (bus_done) begin
                    d.rvalid = 1'b1;
                    d.rdata = bus_rdata;
                    d.rstatus = fwsr_pkg::ST_OK;
                    if (q.kind == fwsr_pkg::CMD_TIMER &&
                        bus_rdata[fwsr_pkg::BIT_ERASE_TIMER]) begin
                        d.rstatus = fwsr_pkg::ST_ERASE_STARTED;
                    end
                    d.st = T_IDLE;
                end
            end
            T_RD1, T_RD2, T_RD3: begin
                if (bus_done) begin
                    d.first = bus_rdata[7:0];
                    d.rdata = bus_rdata;
                    d.reads = (q.reads == 2'h3) ? q.reads : q.reads + 2'h1;
                    d.start = 1'b1;
                    d.wr = 1'b0;
                    if (q.abort || cmd_abort) begin
                        d.start = 1'b0;
                        d.st = T_IDLE;
                    end else if (q.st == T_RD1) begin
                        d.st = T_RD2;
                    end else if (!tog1) begin
                        d.start = 1'b0;
                        d.rvalid = 1'b1;
                        d.rstatus = (tog2 && q.reads == 2'h1)
                                    ? fwsr_pkg::ST_SUSPENDED
                                    : fwsr_pkg::ST_OK;
                        d.st = T_IDLE;
                    end else if (q.st == T_RD3) begin
                        d.wr = 1'b1;
                        d.baddr = fwsr_pkg::RESET_CMD_ADDR;
                        d.bdata = fwsr_pkg::RESET_CMD_DATA;
                        d.st = T_RST;
                    end else if (bus_rdata[fwsr_pkg::BIT_TIMEOUT]) begin
                        d.st = T_RD3;
                    end
                end
            end
            T_RST: begin
                if (bus_done) begin
                    d.rvalid = 1'b1;
                    d.rstatus = fwsr_pkg::ST_FAIL;
                    d.st = T_IDLE;
                end
            end
            default: d = RST;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign cmd_ready = q.ready;
    assign rsp_valid = q.rvalid;
    assign rsp_status = q.rstatus;
    assign rsp_data = q.rdata;
    assign busy = q.busy;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_poll_double: assert property (
        rsp_valid && $past(q.st) inside {T_RD2, T_RD3} |-> q.reads >= 2'h2)
        else $error("Poll answered before two status reads");
    chk_fail_reset: assert property (
        rsp_valid && rsp_status == fwsr_pkg::ST_FAIL |-> $past(q.st) == T_RST)
        else $error("Failure reported without reset command");
    chk_reset_write: assert property (
        q.st == T_RST && q.start |-> q.wr && q.bdata == 16'h00F0)
        else $error("Reset command not a write of F0");
    chk_abort_idle: assert property (
        q.st inside {T_RD1, T_RD2, T_RD3} && (q.abort || cmd_abort) &&
        bus_done |=> q.st == T_IDLE && !rsp_valid)
        else $error("Abort did not end the poll");
    chk_poll_addr: assert property (
        q.start && !q.wr && q.st != T_IDLE |-> q.baddr == q.addr)
        else $error("Status read at wrong address");
    chk_busy_level: assert property (
        !ready_busy_n [*3] |=> busy)
        else $error("Busy not shown for low ready wire");
    chk_timer_status: assert property (
        q.st == T_USER && bus_done && q.kind == fwsr_pkg::CMD_TIMER
        |=> rsp_status == (bus_rdata[3] ? 2'h3 : 2'h0))
        else $error("Erase timer status wrong");
    chk_ready_idle: assert property (cmd_ready |-> q.st == T_IDLE)
        else $error("Command accepted outside idle");

    cov_poll_ok: cover property (
        rsp_valid && rsp_status == fwsr_pkg::ST_OK && $past(q.st) == T_RD2);
    cov_poll_fail: cover property (
        rsp_valid && rsp_status == fwsr_pkg::ST_FAIL);
    cov_suspended: cover property (
        rsp_valid && rsp_status == fwsr_pkg::ST_SUSPENDED);
    cov_timer: cover property (
        rsp_valid && rsp_status == fwsr_pkg::ST_ERASE_STARTED);

endmodule : fwsr_ctrl
`default_nettype wire

// ### dv/fwsr_flash_model.sv
// Behavioural flash that answers reads, writes and status polling.
// Assumes the bench pulls ready/busy up and sets the run state.
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model (
    // Flash pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [21:0] a,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe_n,
    output logic [15:0] dq_i,
    // Open-drain ready/busy, low while pulling
    output logic rb_oe_n
);
    // ********
    // Run state, set by the bench while the host idles
    // ********
    int busy_left = 0;
    int pend = 0;
    int reads = 0;
    logic fail = 1'b0;
    logic susp = 1'b0;
    logic timer = 1'b0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic [15:0] hold = 16'h0000;
    logic [21:0] last_a = 22'h000000;
    logic [21:0] last_wa = 22'h000000;
    logic [15:0] last_wd = 16'h0000;
    logic [15:0] word;
    logic act;
    assign act = (busy_left != 0) || fail;
    assign word = (act || susp) ?
        {8'h00, susp, t1, fail, 1'b0, timer, t2, 2'h0} :
        a[15:0] ^ 16'h5A5A;
    assign rb_oe_n = !act;
    assign dq_i = (!ce_n && !oe_n) ? word : (!dq_oe_n ? dq_o : hold);
    always @(posedge (ce_n | oe_n)) begin
        hold <= ~word;
        reads <= reads + 1;
        last_a <= a;
        if (act) begin
            t1 <= ~t1;
        end
        if (act || susp) begin
            t2 <= ~t2;
        end
        if (busy_left > 0) begin
            busy_left <= busy_left - 1;
        end
    end
    always @(posedge we_n) begin
        last_wa <= a;
        last_wd <= dq_o;
        busy_left <= pend;
        if (dq_o[7:0] == 8'hF0) begin
            fail <= 1'b0;
            busy_left <= 0;
        end
    end
endmodule : fwsr_flash_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the flash status polling controller.
// Assumes the behavioural flash model on the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, resetn, cmd_valid, cmd_abort, cmd_ready, rsp_valid, busy;
    logic [1:0] cmd_kind, rsp_status;
    logic [21:0] cmd_addr, a;
    logic [15:0] cmd_wdata, rsp_data, dq_o, dq_i;
    logic ce_n, oe_n, we_n, dq_oe_n, rb_oe_n, ready_busy_n;
    int errors = 0;
    int comparisons = 0;
    logic got;

    fwsr_ctrl dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_abort(cmd_abort), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_status(rsp_status),
        .rsp_data(rsp_data), .busy(busy), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .a(a), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i),
        .ready_busy_n(ready_busy_n));
    fwsr_flash_model flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .a(a), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i),
        .rb_oe_n(rb_oe_n));
    assign ready_busy_n = rb_oe_n ? 1'b1 : 1'b0;

    // ********
    // Helpers
    // ********
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t ns: %s", $time, m);
        end
    endtask : chk

    task automatic cmd(input logic [1:0] k, input logic [21:0] ad,
                       input logic [15:0] wd);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_addr <= ad;
        cmd_wdata <= wd;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : cmd

    task automatic wait_rsp(input int lim);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clk);
            got = (rsp_valid === 1'b1);
        end
    endtask : wait_rsp

    task automatic op(input logic [1:0] k, input logic [21:0] ad,
                      input logic [15:0] wd, input logic [1:0] st);
        cmd(k, ad, wd);
        wait_rsp(3000);
        chk(got, "no answer");
        chk(rsp_status === st, "wrong answer status");
    endtask : op

    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // ********
    // Scenarios
    // ********
    task automatic t_read();
        int r0;
        r0 = flash.reads;
        chk(ce_n === 1'b1 && oe_n === 1'b1 && we_n === 1'b1, "idle");
        chk(dq_oe_n === 1'b1 && busy === 1'b0, "idle bus");
        op(fwsr_pkg::CMD_READ, 22'h001234, 16'h0000, fwsr_pkg::ST_OK);
        chk(rsp_data === (16'h1234 ^ 16'h5A5A), "read data");
        chk(flash.last_a === 22'h001234, "read address");
        chk(flash.reads - r0 === 1, "read count");
    endtask : t_read

    task automatic t_program();
        int r0;
        flash.pend = 5;
        op(fwsr_pkg::CMD_WRITE, 22'h000100, 16'h0055, fwsr_pkg::ST_OK);
        flash.pend = 0;
        chk(flash.last_wd === 16'h0055, "write data");
        repeat (6) @(posedge clk);
        chk(busy === 1'b1, "busy not seen");
        r0 = flash.reads;
        op(fwsr_pkg::CMD_POLL, 22'h000100, 16'h0000, fwsr_pkg::ST_OK);
        chk(flash.reads - r0 >= 6, "poll ended early");
        chk(rsp_data === (16'h0100 ^ 16'h5A5A), "array after poll");
        repeat (6) @(posedge clk);
        chk(busy === 1'b0, "busy stuck");
    endtask : t_program

    task automatic t_fail();
        flash.fail = 1'b1;
        op(fwsr_pkg::CMD_POLL, 22'h000200, 16'h0000, fwsr_pkg::ST_FAIL);
        chk(rsp_data[5] === 1'b1, "timeout bit");
        chk(flash.last_wd === 16'h00F0, "reset data");
        chk(flash.last_wa === 22'h000000, "reset address");
        chk(flash.fail === 1'b0, "still failed");
    endtask : t_fail

    task automatic t_suspend();
        flash.susp = 1'b1;
        repeat (6) @(posedge clk);
        chk(busy === 1'b0, "busy in suspend");
        op(fwsr_pkg::CMD_POLL, 22'h000300, 16'h0000,
           fwsr_pkg::ST_SUSPENDED);
        chk(rsp_data[7] === 1'b1, "suspend polling bit");
        flash.susp = 1'b0;
    endtask : t_suspend

    task automatic t_timer();
        flash.busy_left = -1;
        for (int b = 0; b < 2; b++) begin
            flash.timer = b[0];
            op(fwsr_pkg::CMD_TIMER, 22'h000400, 16'h0000,
               b ? fwsr_pkg::ST_ERASE_STARTED : fwsr_pkg::ST_OK);
            chk(rsp_data[3] === b[0], "timer bit");
        end
        flash.timer = 1'b0;
        flash.busy_left = 0;
    endtask : t_timer

    task automatic t_abort();
        flash.busy_left = -1;
        cmd(fwsr_pkg::CMD_POLL, 22'h000500, 16'h0000);
        repeat (150) @(posedge clk);
        cmd_abort <= 1'b1;
        @(posedge clk);
        cmd_abort <= 1'b0;
        wait_rsp(200);
        chk(got === 1'b0, "answer after abort");
        chk(cmd_ready === 1'b1, "not idle after abort");
        flash.busy_left = 2;
        op(fwsr_pkg::CMD_POLL, 22'h000500, 16'h0000, fwsr_pkg::ST_OK);
    endtask : t_abort

    // ********
    // Clock, reset, sequence and watchdog
    // ********
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = 2'h0;
        cmd_addr = 22'h000000;
        cmd_wdata = 16'h0000;
        cmd_abort = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_read();
        t_program();
        t_fail();
        t_suspend();
        t_timer();
        t_abort();
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        results();
    end
endmodule : tb_top
`default_nettype wire
